// ===== inc/cmt_pkg.sv
// package of constants and types for the converter mode, trim and offset register bank
package cmt_pkg;

   // ***************************************************************
   // register pointers
   // ***************************************************************
   localparam logic [7:0] CMT_PTR_CONFIG = 8'h0A; // pointer of the register holding the mode field
   localparam logic [7:0] CMT_PTR_POS_TRIM = 8'h0B; // positive trim dac setup
   localparam logic [7:0] CMT_PTR_NEG_TRIM = 8'h0C; // negative trim dac setup
   localparam logic [7:0] CMT_PTR_OFS_HI = 8'h0D; // offset coefficient, high byte
   localparam logic [7:0] CMT_PTR_OFS_LO = 8'h0E; // offset coefficient, low byte

   // ***************************************************************
   // field positions and reset values
   // ***************************************************************
   localparam int CMT_MODE_MSB = 2; // mode field top bit
   localparam int CMT_TRIM_EN_BIT = 7; // trim enable position
   localparam logic [7:0] CMT_CONFIG_RST = 8'h00; // mode field resets to idle
   localparam logic [7:0] CMT_TRIM_RST = 8'h00; // trim disconnected, code zero
   localparam logic [15:0] CMT_OFS_RST = 16'h8000; // offset coefficient midscale
   localparam logic [6:0] CMT_TRIM_CODE_MAX = 7'h7F; // full seven-bit trim code range

   // ***************************************************************
   // converter modes
   // ***************************************************************
   typedef enum logic [2:0] {
      CMT_MODE_IDLE = 3'h0,
      CMT_MODE_CONT = 3'h1,
      CMT_MODE_SINGLE = 3'h2,
      CMT_MODE_PDOWN = 3'h3,
      CMT_MODE_RSV4 = 3'h4,
      CMT_MODE_OFS_CAL = 3'h5,
      CMT_MODE_GAIN_CAL = 3'h6,
      CMT_MODE_RSV7 = 3'h7
   } cmt_mode_type;

   // trim dac setup as driven to the analog core
   typedef struct packed {
      logic enable; // dac connected to its input
      logic [6:0] code; // dac value
   } cmt_trim_type;

   // register write and read port
   typedef struct packed {
      logic wr; // one-cycle write strobe
      logic rd; // one-cycle read strobe
      logic [7:0] ptr; // register pointer
      logic [7:0] wdata; // write byte
   } cmt_req_type;

endpackage

// ===== rtl/cmt_offset_sub.sv
// offset removal stage: subtracts the scaled coefficient from a raw result
`timescale 1ns/100ps
`default_nettype none
module cmt_offset_sub (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic raw_valid,
   input wire logic [23:0] raw_data,
   input wire logic [15:0] offset_coef,
   output logic out_valid,
   output logic [23:0] out_data
);
   import cmt_pkg::*;

   // ***************************************************************
   // arithmetic
   // ***************************************************************
   // coefficient is signed about midscale; one lsb is worth 2^5 result lsbs, so
   // the coefficient span is an eighth of the 8 pF result span (1 pF), lsb near 16 aF
   // a shift of 4 would leave only half a picofarad of correction range
   wire logic signed [16:0] ofs_signed;
   wire logic signed [24:0] ofs_scaled;
   wire logic signed [24:0] diff;
   assign ofs_signed = $signed({1'b0, offset_coef}) - $signed({1'b0, CMT_OFS_RST});
   assign ofs_scaled = {{3{ofs_signed[16]}}, ofs_signed, 5'h00};
   assign diff = $signed({1'b0, raw_data}) - ofs_scaled;

   // registered result; data passes one cycle after its strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         out_data <= 24'h000000;
      end else begin
         out_valid <= raw_valid;
         out_data <= diff[23:0];
      end
   end

endmodule
`default_nettype wire

// ===== rtl/cmt_regs.sv
// register bank for converter mode, trim dac setup and capacitive offset coefficient
// Behaviour
// - decode mode codes to converter operations
// - positive trim enable bit 7 connects dac
// - positive trim code in bits 6:0
// - negative trim enable bit 7 connects dac
// - negative trim code in bits 6:0
// - trim registers at 0x0B/0x0C, reset zero
// - 16-bit offset at 0x0D/0x0E, reset 0x8000
// - offset subtracted digitally from capacitive result
// - offset calibration overwrites coefficient automatically
// - coefficient lsb under 32 aF, 1 pF span
// - one coefficient shared by both channels
`timescale 1ns/100ps
`default_nettype none
module cmt_regs (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire cmt_pkg::cmt_req_type req,
   output logic [7:0] rdata,
   output logic rvalid,
   output cmt_pkg::cmt_mode_type mode,
   output logic conv_run,
   output logic pdown,
   output logic ofs_cal_run,
   output logic gain_cal_run,
   output cmt_pkg::cmt_trim_type positive_trim,
   output cmt_pkg::cmt_trim_type negative_trim,
   output logic [15:0] offset_coef,
   input wire logic cal_done,
   input wire logic [15:0] cal_zero_value,
   input wire logic raw_valid,
   input wire logic [23:0] raw_data,
   output logic res_valid,
   output logic [23:0] res_data
);
   import cmt_pkg::*;

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   // true when the request pointer equals the given pointer, with or without a strobe
   function automatic logic hit(input cmt_req_type r, input logic [7:0] p);
      hit = r.ptr == p;
   endfunction

   // registers
   logic [2:0] mode_q; // mode field
   logic [7:0] pos_trim_q; // positive trim register
   logic [7:0] neg_trim_q; // negative trim register
   logic [15:0] ofs_q; // offset coefficient
   logic [7:0] rdata_q; // read byte
   logic rvalid_q; // read answer strobe

   // named write decodes
   wire logic wr_cfg;
   wire logic wr_pos;
   wire logic wr_neg;
   wire logic wr_ofs_hi;
   wire logic wr_ofs_lo;
   assign wr_cfg = req.wr && hit(req, CMT_PTR_CONFIG);
   assign wr_pos = req.wr && hit(req, CMT_PTR_POS_TRIM);
   assign wr_neg = req.wr && hit(req, CMT_PTR_NEG_TRIM);
   assign wr_ofs_hi = req.wr && hit(req, CMT_PTR_OFS_HI);
   assign wr_ofs_lo = req.wr && hit(req, CMT_PTR_OFS_LO);

   // ***************************************************************
   // mode field
   // ***************************************************************
   // mode lives in bits 2:0 of the config byte
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= CMT_CONFIG_RST[CMT_MODE_MSB:0];
      end else if (cal_done && mode_q == CMT_MODE_OFS_CAL) begin
         // offset calibration mode falls back to idle when the core finishes; gain calibration stays set
         mode_q <= CMT_MODE_IDLE;
      end else if (wr_cfg) begin
         mode_q <= req.wdata[CMT_MODE_MSB:0];
      end
   end

   // map field codes onto core controls
   wire cmt_mode_type mode_dec;
   assign mode_dec = cmt_mode_type'(mode_q);
   logic run_d;
   logic pdown_d;
   logic ofs_d;
   logic gain_d;
   always_comb begin
      run_d = 1'b0;
      pdown_d = 1'b0;
      ofs_d = 1'b0;
      gain_d = 1'b0;
      unique case (mode_dec)
         CMT_MODE_IDLE: ;
         CMT_MODE_CONT: run_d = 1'b1;
         CMT_MODE_SINGLE: run_d = 1'b1;
         CMT_MODE_PDOWN: pdown_d = 1'b1;
         CMT_MODE_OFS_CAL: ofs_d = 1'b1;
         CMT_MODE_GAIN_CAL: gain_d = 1'b1;
         CMT_MODE_RSV4: ;
         CMT_MODE_RSV7: ;
      endcase
   end

   // ***************************************************************
   // trim dac setup
   // ***************************************************************
   // both trim registers reset to disconnected, code zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pos_trim_q <= CMT_TRIM_RST;
         neg_trim_q <= CMT_TRIM_RST;
      end else begin
         if (wr_pos) begin
            pos_trim_q <= req.wdata;
         end
         if (wr_neg) begin
            neg_trim_q <= req.wdata;
         end
      end
   end

   // ***************************************************************
   // offset coefficient
   // ***************************************************************
   // calibration result wins over a host write in the same cycle
   // a single coefficient serves every capacitive channel
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ofs_q <= CMT_OFS_RST;
      end else if (cal_done && mode_q == CMT_MODE_OFS_CAL) begin
         ofs_q <= cal_zero_value;
      end else begin
         // coefficient spans two byte pointers, high first
         if (wr_ofs_hi) begin
            ofs_q[15:8] <= req.wdata;
         end
         if (wr_ofs_lo) begin
            ofs_q[7:0] <= req.wdata;
         end
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   // unmapped pointers read zero; reserved config bits read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (hit(req, CMT_PTR_CONFIG)) begin
         rd_mux = {5'h00, mode_q};
      end else if (hit(req, CMT_PTR_POS_TRIM)) begin
         rd_mux = pos_trim_q;
      end else if (hit(req, CMT_PTR_NEG_TRIM)) begin
         rd_mux = neg_trim_q;
      end else if (hit(req, CMT_PTR_OFS_HI)) begin
         rd_mux = ofs_q[15:8];
      end else if (hit(req, CMT_PTR_OFS_LO)) begin
         rd_mux = ofs_q[7:0];
      end
   end

   // host reads back the coefficient to keep per-channel copies
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
         if (req.rd) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // ***************************************************************
   // registered core outputs
   // ***************************************************************
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         conv_run <= 1'b0;
         pdown <= 1'b0;
         ofs_cal_run <= 1'b0;
         gain_cal_run <= 1'b0;
         mode <= CMT_MODE_IDLE;
         positive_trim <= '0;
         negative_trim <= '0;
         offset_coef <= CMT_OFS_RST;
      end else begin
         conv_run <= run_d;
         pdown <= pdown_d;
         ofs_cal_run <= ofs_d;
         gain_cal_run <= gain_d;
         mode <= mode_dec;
         // enable bit gates the positive dac connection
         positive_trim.enable <= pos_trim_q[CMT_TRIM_EN_BIT];
         // positive code taken from low seven bits
         positive_trim.code <= pos_trim_q[6:0];
         // enable bit gates the negative dac connection
         negative_trim.enable <= neg_trim_q[CMT_TRIM_EN_BIT];
         // negative code taken from low seven bits
         negative_trim.code <= neg_trim_q[6:0];
         offset_coef <= ofs_q;
      end
   end

   assign rdata = rdata_q;
   assign rvalid = rvalid_q;

   // ***************************************************************
   // offset removal
   // ***************************************************************
   // digital subtraction of the coefficient
   // scaling of one lsb is fixed inside the stage
   cmt_offset_sub u_sub (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .raw_valid(raw_valid),
      .raw_data(raw_data),
      .offset_coef(ofs_q),
      .out_valid(res_valid),
      .out_data(res_data)
   );

   // ***************************************************************
   // checks
   // ***************************************************************
   trim_reset_a: assert property (
      @(posedge sys_clk) $rose(nrst) |-> pos_trim_q == 8'h00 && neg_trim_q == 8'h00)
      else $error("trim registers not zero after reset");

   ofs_reset_a: assert property (
      @(posedge sys_clk) $rose(nrst) |-> ofs_q == 16'h8000)
      else $error("offset coefficient not midscale after reset");

   pos_trim_out_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_pos ##2 1 |-> positive_trim.enable == $past(req.wdata[7], 2))
      else $error("positive trim enable not applied");

   neg_code_out_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_neg ##2 1 |-> negative_trim.code == $past(req.wdata[6:0], 2))
      else $error("negative trim code not applied");

   cal_update_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cal_done && mode_q == 3'h5 |=> ofs_q == $past(cal_zero_value) && mode_q == 3'h0)
      else $error("calibration did not update coefficient");

   mode_field_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cfg && !cal_done |=> mode_q == $past(req.wdata[2:0]))
      else $error("mode field not written");

   mode_decode_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      mode_q == 3'h3 |=> pdown && !conv_run)
      else $error("power-down not decoded");

   reserved_mode_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (mode_q == 3'h4 || mode_q == 3'h7) |=> !conv_run && !pdown && !ofs_cal_run)
      else $error("reserved mode started an operation");

   ofs_write_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_ofs_lo && !cal_done |=> ofs_q[7:0] == $past(req.wdata))
      else $error("offset low byte not written");

   pos_code_out_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_pos ##2 1 |-> positive_trim.code == $past(req.wdata[6:0], 2))
      else $error("positive trim code not applied");

   neg_en_out_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_neg ##2 1 |-> negative_trim.enable == $past(req.wdata[7], 2))
      else $error("negative trim enable not applied");

   ofs_hi_write_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_ofs_hi && !cal_done |=> ofs_q[15:8] == $past(req.wdata))
      else $error("offset high byte not written");

   stray_cal_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cal_done && mode_q != 3'h5 && !wr_ofs_hi && !wr_ofs_lo |=> ofs_q == $past(ofs_q))
      else $error("calibration outside offset mode changed coefficient");

   gain_decode_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      mode_q == 3'h6 |=> gain_cal_run && !ofs_cal_run && !conv_run)
      else $error("gain calibration not decoded");

   trim_read_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      req.rd && req.ptr == 8'h0B |=> rvalid && rdata == $past(pos_trim_q))
      else $error("positive trim read back wrong");

   zero_offset_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      raw_valid && ofs_q == 16'h8000 |=> res_valid && res_data == $past(raw_data))
      else $error("midscale coefficient altered the result");

endmodule
`default_nettype wire

// ===== dv/cmt_host_model.sv
// host controller model issuing register reads and writes to the bank
`timescale 1ns/100ps
`default_nettype none
module cmt_host_model (
   input wire logic sys_clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output var cmt_pkg::cmt_req_type req
);
   import cmt_pkg::*;

   // idle bus at time zero, no strobe
   initial begin
      req = '0;
   end

   // one write strobe; a released bus shows inverted data so stale values never match
   task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] data);
      @(negedge sys_clk);
      req <= '{wr: 1'b1, rd: 1'b0, ptr: ptr, wdata: data};
      @(negedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b0, ptr: ~ptr, wdata: ~data};
   endtask

   // one read strobe; the answer stands for one cycle, sampled mid-cycle
   task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
      @(negedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b1, ptr: ptr, wdata: 8'h00};
      @(negedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b0, ptr: ~ptr, wdata: 8'hFF};
      ok = rvalid;
      data = rdata;
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the mode, trim and offset register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cmt_pkg::*;
   logic sys_clk;
   logic nrst;
   logic cal_done;
   logic [15:0] cal_zero_value;
   logic raw_valid;
   logic [23:0] raw_data;
   cmt_req_type req;
   logic [7:0] rdata;
   logic rvalid;
   cmt_mode_type mode;
   logic conv_run, pdown, ofs_cal_run, gain_cal_run, res_valid;
   cmt_trim_type positive_trim, negative_trim;
   logic [15:0] offset_coef;
   logic [23:0] res_data;
   int miscompares = 0;
   int cmp_count = 0;

   cmt_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .mode(mode), .conv_run(conv_run), .pdown(pdown), .ofs_cal_run(ofs_cal_run),
      .gain_cal_run(gain_cal_run), .positive_trim(positive_trim),
      .negative_trim(negative_trim), .offset_coef(offset_coef), .cal_done(cal_done),
      .cal_zero_value(cal_zero_value), .raw_valid(raw_valid), .raw_data(raw_data),
      .res_valid(res_valid), .res_data(res_data));
   cmt_host_model host (.sys_clk(sys_clk), .rdata(rdata), .rvalid(rvalid), .req(req));

   // ***************************************************************
   // clock and watchdog
   // ***************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // whole run is about 150 cycles, so this only trips on a hang
   initial begin
      repeat (4000) @(posedge sys_clk);
      miscompares++;
      $display("ERROR %0t watchdog expired", $time);
      stop_test;
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.rd_reg(ptr, d, ok);
      check(ok, 1'b1, "read answer");
      check(d, exp, "read byte");
   endtask
   // trim write, then core copy and read back
   task automatic trim_case(input logic [7:0] ptr, input logic [7:0] val);
      host.wr_reg(ptr, val);
      step(2);
      check(ptr == CMT_PTR_POS_TRIM ? positive_trim : negative_trim, val, "trim");
      rd_chk(ptr, val);
   endtask
   task automatic set_coef(input logic [15:0] v);
      host.wr_reg(CMT_PTR_OFS_HI, v[15:8]);
      host.wr_reg(CMT_PTR_OFS_LO, v[7:0]);
      step(2);
   endtask
   // raw result in, corrected result expected one cycle later
   task automatic res_chk(input logic [23:0] raw, input logic [15:0] coef);
      @(negedge sys_clk);
      raw_valid <= 1'b1;
      raw_data <= raw;
      @(negedge sys_clk);
      raw_valid <= 1'b0;
      raw_data <= ~raw;
      check(res_valid, 1'b1, "result strobe");
      check(res_data, raw - (({8'h00, coef} - 24'h008000) << 5), "result");
   endtask
   task automatic cal_pulse(input logic [15:0] v);
      @(negedge sys_clk);
      cal_done <= 1'b1;
      cal_zero_value <= v;
      @(negedge sys_clk);
      cal_done <= 1'b0;
      cal_zero_value <= ~v;
      step(1);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ***************************************************************
   // test sequence
   // ***************************************************************
   initial begin
      nrst = 1'b0;
      cal_done = 1'b0;
      cal_zero_value = 16'h0000;
      raw_valid = 1'b0;
      raw_data = 24'h000000;
      step(10);
      nrst <= 1'b1;
      check(offset_coef, CMT_OFS_RST, "coef reset");
      check({positive_trim, negative_trim}, 16'h0000, "trim reset");
      rd_chk(CMT_PTR_CONFIG, 8'h00);
      rd_chk(CMT_PTR_POS_TRIM, 8'h00);
      rd_chk(CMT_PTR_NEG_TRIM, 8'h00);
      rd_chk(CMT_PTR_OFS_HI, 8'h80);
      rd_chk(CMT_PTR_OFS_LO, 8'h00);
      $display("test reset values done");
      // every code, upper bits set to show they are dropped
      for (int m = 0; m < 8; m++) begin
         host.wr_reg(CMT_PTR_CONFIG, 8'hF8 | 8'(m));
         step(2);
         check(mode, 24'(m), "mode");
         check(conv_run, m == 1 || m == 2, "run");
         check({pdown, ofs_cal_run, gain_cal_run}, {m == 3, m == 5, m == 6}, "ctl");
         rd_chk(CMT_PTR_CONFIG, 8'(m));
      end
      $display("test modes done");
      trim_case(CMT_PTR_POS_TRIM, 8'h85);
      trim_case(CMT_PTR_POS_TRIM, 8'h7F);
      trim_case(CMT_PTR_NEG_TRIM, 8'hFF);
      trim_case(CMT_PTR_NEG_TRIM, 8'h80);
      host.wr_reg(8'h0F, 8'hFF);
      rd_chk(8'h0F, 8'h00);
      check({positive_trim, negative_trim}, 16'h7F80, "unmapped write");
      $display("test trims done");
      res_chk(24'h123456, 16'h8000);
      set_coef(16'h0000);
      res_chk(24'hFFFFF0, 16'h0000);
      set_coef(16'hFFFF);
      check(offset_coef, 16'hFFFF, "coef write");
      res_chk(24'h000010, 16'hFFFF);
      $display("test offset path done");
      // calibration strobe outside offset mode must not touch the coefficient
      host.wr_reg(CMT_PTR_CONFIG, 8'h01);
      cal_pulse(16'h1111);
      check(offset_coef, 16'hFFFF, "stray cal");
      host.wr_reg(CMT_PTR_CONFIG, 8'h05);
      cal_pulse(16'hA5C3);
      check(offset_coef, 16'hA5C3, "cal coef");
      check({mode, ofs_cal_run}, 4'h0, "cal exit");
      rd_chk(CMT_PTR_OFS_HI, 8'hA5);
      rd_chk(CMT_PTR_OFS_LO, 8'hC3);
      // second channel calibration overwrites the single shared coefficient
      host.wr_reg(CMT_PTR_CONFIG, 8'h05);
      cal_pulse(16'h7E01);
      check(offset_coef, 16'h7E01, "shared coef");
      set_coef(16'hA5C3);
      res_chk(24'h400000, 16'hA5C3);
      $display("test calibration done");
      @(negedge sys_clk);
      nrst <= 1'b0;
      step(1);
      check(offset_coef, CMT_OFS_RST, "mid reset");
      check({positive_trim, negative_trim}, 16'h0000, "mid reset trim");
      nrst <= 1'b1;
      rd_chk(CMT_PTR_POS_TRIM, 8'h00);
      rd_chk(CMT_PTR_OFS_HI, 8'h80);
      $display("test second reset done");
      stop_test;
   end
endmodule
`default_nettype wire
